// ### rtl/interval_counter_defs.svh
// Purpose: offsets, field positions and reset values of the interval counter
// Assumes: byte-wide host i/o port, counters 0..2 at offsets 0xC..0xE
// Notes:   definitions only
`ifndef INTERVAL_COUNTER_DEFS_SVH
`define INTERVAL_COUNTER_DEFS_SVH
`define ICC_OFS_COUNTER0     4'hC
`define ICC_OFS_COUNTER1     4'hD
`define ICC_OFS_COUNTER2     4'hE
`define ICC_OFS_COMMAND      4'hF
`define ICC_POS_DECADE       0
`define ICC_POS_FUNC_LO      1
`define ICC_POS_FUNC_HI      3
`define ICC_POS_ORDER_LO     4
`define ICC_POS_ORDER_HI     5
`define ICC_POS_TARGET_LO    6
`define ICC_POS_TARGET_HI    7
`define ICC_POS_LATCH_VALUE_N 5
`define ICC_POS_REPORT_N     4
`define ICC_POS_PICK_FIRST   1
`define ICC_POS_REPORT_OUT   7
`define ICC_POS_REPORT_NULL  6
`define ICC_RST_CONFIG       6'h00
`define ICC_RST_COUNT        16'h0000
`define ICC_BIN_FULL         16'hFFFF
`define ICC_BCD_FULL         16'h9999
`endif

// ### rtl/interval_counter_pkg.sv
// Purpose: shared types of the interval counter
// Assumes: nothing
// Notes:   constants live in interval_counter_defs.svh
package interval_counter_pkg;
  typedef enum logic [1:0] {ORDER_LATCH, ORDER_LOW, ORDER_HIGH, ORDER_PAIR} byte_order_t;
  typedef enum logic [2:0] {
    FN_TERMINAL, FN_ONE_SHOT, FN_RATE, FN_SQUARE, FN_SOFT_STROBE, FN_HARD_STROBE
  } function_t;
  typedef struct packed {
    logic [1:0] byte_order;
    logic [2:0] func;
    logic       decade;
  } config_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } port_access_t;
  typedef struct packed {
    logic       set_mode;
    logic       latch_count;
    logic       latch_report;
  } command_t;
endpackage

// ### rtl/counter_channel.sv
// Purpose: one presettable 16-bit down counter with its data port
// Assumes: count edge i_tick is one mclk pulse, i_gate level
// Notes:   only register and sequencing behaviour, simplified output wave
`timescale 1ns/100ps
`include "interval_counter_defs.svh"
module counter_channel (
  input  wire logic                          i_mclk,
  input  wire logic                          i_resetn,
  input  wire interval_counter_pkg::command_t     i_cmd,
  input  wire interval_counter_pkg::config_t      i_cfg,
  input  wire interval_counter_pkg::port_access_t i_acc,
  input  wire logic                          i_tick,
  input  wire logic                          i_gate,
  output logic [7:0]                         o_rdata,
  output logic                               o_out
);
  interval_counter_pkg::config_t cfg_r;
  logic [15:0] count_r, preset_r, hold_r;
  logic [7:0]  load_low_r, report_r;
  logic        toggle_r, rd_toggle_r, hold_valid_r, report_valid_r, null_r, out_r;
  logic        load_pend_r;
  logic [15:0] count_nxt, preset_nxt;
  logic        load_done;
  interval_counter_pkg::byte_order_t order;

  assign order = interval_counter_pkg::byte_order_t'(cfg_r.byte_order);

  // configuration; a new program resets the byte toggles
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      cfg_r <= `ICC_RST_CONFIG;
    end else if (i_cmd.set_mode) begin
      cfg_r <= i_cfg;
    end
  end

  // next preset from a data-port write, honouring the byte order
  always_comb begin
    preset_nxt = preset_r;
    load_done  = 1'b0;
    case (order)
      interval_counter_pkg::ORDER_LOW: begin
        preset_nxt = {8'h00, i_acc.data};
        load_done  = 1'b1;
      end
      interval_counter_pkg::ORDER_HIGH: begin
        preset_nxt = {i_acc.data, 8'h00};
        load_done  = 1'b1;
      end
      interval_counter_pkg::ORDER_PAIR: begin
        preset_nxt = {i_acc.data, load_low_r};
        load_done  = toggle_r;
      end
      default: begin
        load_done  = 1'b0;
      end
    endcase
  end

  // write side: low/high toggle and preset capture
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      toggle_r    <= 1'b0;
      load_low_r  <= 8'h00;
      preset_r    <= `ICC_RST_COUNT;
      load_pend_r <= 1'b0;
    end else begin
      if (i_cmd.set_mode) begin
        toggle_r <= 1'b0;
      end else if (i_acc.wr) begin
        if (order == interval_counter_pkg::ORDER_PAIR) begin
          toggle_r <= ~toggle_r;
        end
        if (!toggle_r) begin
          load_low_r <= i_acc.data;
        end
        if (load_done) begin
          preset_r    <= preset_nxt;
          load_pend_r <= 1'b1;
        end
      end
      // transfer happens on the next count edge, when the load is taken
      if (load_pend_r && i_tick && !(i_acc.wr && load_done)) begin
        load_pend_r <= 1'b0;
      end
    end
  end

  // null count: set by a complete write, cleared only by the transfer
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      null_r <= 1'b0;
    end else if (i_cmd.set_mode || (i_acc.wr && load_done)) begin
      null_r <= 1'b1;
    end else if (load_pend_r && i_tick) begin
      null_r <= 1'b0;
    end
  end

  // decrement in binary or four decades
  function automatic logic [15:0] dec_count(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    r = v;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      r = v;
      for (int d = 0; d < 4; d++) begin
        if (r[d*4 +: 4] != 4'h0) begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          break;
        end
        r[d*4 +: 4] = 4'h9;
      end
    end
    return r;
  endfunction

  // count 0 wraps to full scale: 65535 or 9999
  always_comb begin
    count_nxt = dec_count(count_r, cfg_r.decade);
  end

  // counting element and a plain output level
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      count_r <= `ICC_RST_COUNT;
      out_r   <= 1'b0;
    end else if (i_tick) begin
      if (load_pend_r) begin
        count_r <= preset_r;
        out_r   <= (cfg_r.func != 3'b000);
      end else if (i_gate) begin
        count_r <= count_nxt;
        if (count_r == 16'h0001) begin
          out_r <= ~out_r;
        end
      end
    end
  end

  // count latch: one hold per counter, ignored while still unread
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      hold_r       <= `ICC_RST_COUNT;
      hold_valid_r <= 1'b0;
    end else begin
      if (i_cmd.latch_count && !hold_valid_r) begin
        hold_r       <= count_r;
        hold_valid_r <= 1'b1;
      end else if (i_acc.rd && !report_valid_r && hold_valid_r &&
                   (order != interval_counter_pkg::ORDER_PAIR || rd_toggle_r)) begin
        hold_valid_r <= 1'b0;
      end
    end
  end

  // status latch; the report byte is read before any count bytes
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      report_r       <= 8'h00;
      report_valid_r <= 1'b0;
    end else if (i_cmd.latch_report && !report_valid_r) begin
      report_r       <= {out_r, null_r, cfg_r};
      report_valid_r <= 1'b1;
    end else if (i_acc.rd && report_valid_r) begin
      report_valid_r <= 1'b0;
    end
  end

  // read toggle in pair mode
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rd_toggle_r <= 1'b0;
    end else if (i_cmd.set_mode) begin
      rd_toggle_r <= 1'b0;
    end else if (i_acc.rd && !report_valid_r &&
                 order == interval_counter_pkg::ORDER_PAIR) begin
      rd_toggle_r <= ~rd_toggle_r;
    end
  end

  // a pending hold hides the live count from reads, never from counting
  logic [15:0] rd_src;
  assign rd_src = hold_valid_r ? hold_r : count_r;

  // read data register: report, then held count, else live count
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_acc.rd) begin
      if (report_valid_r) begin
        o_rdata <= report_r;
      end else if (order == interval_counter_pkg::ORDER_HIGH ||
                   (order == interval_counter_pkg::ORDER_PAIR && rd_toggle_r)) begin
        o_rdata <= rd_src[15:8];
      end else begin
        o_rdata <= rd_src[7:0];
      end
    end
  end

  assign o_out = out_r;
endmodule // counter_channel

// ### rtl/interval_counter_control.sv
// Operation
// - decade bit clear counts 16-bit binary, set counts four decimal decades
// - full count 65535 in binary, 9999 in decade counting
// - function code: terminal, one-shot, rate, square, soft and hard strobe
// - order code: latch, low only, high only, low then high
// - low-then-high mode uses a per-counter toggle for alternate accesses
// - order code 00 copies the live count into a 16-bit hold
// - latching never disturbs counting; unlatched reads see the live count
// - top bits select counter 0, 1, 2 or readback
// - readback: 11, count latch low, status latch low, selects, bit0 zero
// - readback with count latch low latches all selected counts together
// - readback with status latch low returns status on next data read
// - status holds output, null count, and the six programmed bits
// - null count set from count write until transfer to counter
// - three independent presettable 16-bit down counters, one control port
//
// Purpose: control-word decode and three counter channels
// Assumes: one host byte access per cycle, i_wr/i_rd one-cycle strobes
// Notes:   read data appears the cycle after i_rd
`timescale 1ns/100ps
`include "interval_counter_defs.svh"
module interval_counter_control (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic [3:0] i_addr,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_wdata,
  input  wire logic [2:0] i_tick,
  input  wire logic [2:0] i_gate,
  output logic [7:0]      o_rdata,
  output logic [2:0]      o_out,
  output logic [2:0]      o_function_valid
);
  interval_counter_pkg::command_t     cmd [3];
  interval_counter_pkg::port_access_t acc [3];
  interval_counter_pkg::config_t      cfg;
  logic [7:0] ch_rdata [3];
  logic [1:0] rd_sel_r;
  logic       cmd_wr, readback;
  logic [1:0] target;

  assign cmd_wr   = i_wr && (i_addr == `ICC_OFS_COMMAND);
  assign target   = i_wdata[`ICC_POS_TARGET_HI:`ICC_POS_TARGET_LO];
  assign readback = (target == 2'b11);
  assign cfg      = interval_counter_pkg::config_t'(i_wdata[5:0]);

  // per-channel commands and data-port access
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cmd[i].set_mode     = 1'b0;
      cmd[i].latch_count  = 1'b0;
      cmd[i].latch_report = 1'b0;
      if (cmd_wr && !readback && target == 2'(i)) begin
        if (i_wdata[`ICC_POS_ORDER_HI:`ICC_POS_ORDER_LO] == 2'b00) begin
          cmd[i].latch_count = 1'b1;
        end else begin
          cmd[i].set_mode = 1'b1;
        end
      end
      if (cmd_wr && readback && i_wdata[`ICC_POS_PICK_FIRST + i]) begin
        cmd[i].latch_count  = !i_wdata[`ICC_POS_LATCH_VALUE_N];
        cmd[i].latch_report = !i_wdata[`ICC_POS_REPORT_N];
      end
      acc[i].wr   = i_wr && (i_addr == `ICC_OFS_COUNTER0 + 4'(i));
      acc[i].rd   = i_rd && (i_addr == `ICC_OFS_COUNTER0 + 4'(i));
      acc[i].data = i_wdata;
    end
  end

  // the three channels share the control decode
  for (genvar g = 0; g < 3; g++) begin : g_ch
    counter_channel counter_channel_inst (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_cmd    (cmd[g]),
      .i_cfg    (cfg),
      .i_acc    (acc[g]),
      .i_tick   (i_tick[g]),
      .i_gate   (i_gate[g]),
      .o_rdata  (ch_rdata[g]),
      .o_out    (o_out[g])
    );
  end

  // remember which channel answered the last read
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      rd_sel_r <= 2'b00;
    end else if (i_rd && i_addr >= `ICC_OFS_COUNTER0 && i_addr <= `ICC_OFS_COUNTER2) begin
      rd_sel_r <= 2'(i_addr - `ICC_OFS_COUNTER0);
    end
  end

  // function flag per channel: set by any program command, held until reset
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_function_valid <= 3'b000;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (cmd[i].set_mode) begin
          o_function_valid[i] <= 1'b1;
        end
      end
    end
  end

  assign o_rdata = (rd_sel_r == 2'd1) ? ch_rdata[1] :
                   (rd_sel_r == 2'd2) ? ch_rdata[2] : ch_rdata[0];
endmodule // interval_counter_control

// ### bench/interval_counter_checker.sv
// Purpose: port-level checks of interval_counter_control
// Assumes: one-cycle strobes, registered outputs
// Notes:   read data may land one edge late, so holds span two edges
`timescale 1ns/100ps
module interval_counter_checker (
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  input wire logic [3:0] i_addr,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [2:0] i_tick,
  input wire logic [2:0] i_gate,
  input wire logic [7:0] o_rdata,
  input wire logic [2:0] o_out,
  input wire logic [2:0] o_function_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic prog;
  // only a counter select with a real byte order programs a channel
  assign prog = i_wr && i_addr == 4'hF && i_wdata[7:6] != 2'b11 && i_wdata[5:4] != 2'b00;
  sequence s_quiet; (i_tick == 3'h0 && !i_wr) [*2]; endsequence
  sequence s_stale; (i_rd && i_addr == 4'hF) ##1 !i_rd; endsequence
  property p_rst; $rose(i_resetn) |-> o_out == 3'h0 && o_function_valid == 3'h0; endproperty
  property p_hold; (!i_rd && !$past(i_rd)) |=> $stable(o_rdata); endproperty
  property p_stale; s_stale |-> $stable(o_rdata) ##1 $stable(o_rdata); endproperty
  property p_sticky; ($past(o_function_valid) & ~o_function_valid) == 3'h0; endproperty
  property p_cause;
    (o_function_valid & ~$past(o_function_valid)) != 3'h0 |-> $past(prog) || $past(prog, 2);
  endproperty
  property p_nocfg;
    (i_wr && i_addr == 4'hF && (i_wdata[7:6] == 2'b11 || i_wdata[5:4] == 2'b00))
      |=> $stable(o_function_valid);
  endproperty
  property p_unprog; (o_out & ~o_function_valid) == 3'h0; endproperty
  property p_quiet; s_quiet |=> $stable(o_out); endproperty
  a_rst:    assert property (p_rst) else $error("outputs not clear after reset");
  a_hold:   assert property (p_hold) else $error("read data moved without a read");
  a_stale:  assert property (p_stale) else $error("command port read changed data");
  a_sticky: assert property (p_sticky) else $error("programmed flag dropped");
  a_cause:  assert property (p_cause) else $error("programmed flag without write");
  a_nocfg:  assert property (p_nocfg) else $error("latch word programmed a channel");
  a_unprog: assert property (p_unprog) else $error("idle channel output high");
  a_quiet:  assert property (p_quiet) else $error("output moved without a tick");
endmodule // interval_counter_checker
bind interval_counter_control interval_counter_checker interval_counter_checker_inst (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .i_tick(i_tick), .i_gate(i_gate), .o_rdata(o_rdata), .o_out(o_out),
  .o_function_valid(o_function_valid));

// ### bench/tb.sv
// Purpose: self-checking bench of interval_counter_control
// Assumes: first tick after a full count loads it without counting
// Notes:   gates high except counter 1 in the gate-low check, zero presets wrap to full scale
`timescale 1ns/100ps
module tb;
  logic       i_mclk = 1'b0;
  logic       i_resetn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [2:0] i_tick = 3'h0;
  logic [2:0] i_gate = 3'h7;
  logic [7:0] o_rdata;
  logic [2:0] o_out;
  logic [2:0] o_function_valid;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 10;
  logic [7:0] r;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] u;
  logic [5:0] cfg;
  always #12.5 i_mclk = ~i_mclk;
  interval_counter_control interval_counter_control_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .i_tick(i_tick), .i_gate(i_gate), .o_rdata(o_rdata), .o_out(o_out),
    .o_function_valid(o_function_valid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle strobes, launched and dropped on falling edges
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_mclk); i_addr = a; i_wdata = d; i_wr = 1'b1;
    @(negedge i_mclk); i_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_mclk); i_addr = a; i_rd = 1'b1;
    @(negedge i_mclk); i_rd = 1'b0;
    @(negedge i_mclk); d = o_rdata;
  endtask
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a, d[15:8]);
  endtask
  task automatic tick(input logic [2:0] m, input int n);
    repeat (n) begin
      @(negedge i_mclk); i_tick = m;
      @(negedge i_mclk); i_tick = 3'h0;
    end
  endtask
  // expected count after n ticks, decimal borrow when bcd
  function automatic logic [15:0] expect_count(input logic [15:0] x, input logic bcd, input int n);
    int d;
    if (!bcd) return x - 16'(n);
    d = x[15:12] * 1000 + x[11:8] * 100 + x[7:4] * 10 + x[3:0] - n;
    // a borrow past zero wraps to the decade full scale
    d = (d + 10000) % 10000;
    return {4'(d / 1000), 4'((d / 100) % 10), 4'((d / 10) % 10), 4'(d % 10)};
  endfunction
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(negedge i_mclk);
    i_resetn = 1'b1;
    @(negedge i_mclk);
    check(16'({o_out, o_function_valid}), 16'h0000);
    // every function code with a random decade bit, seen in the status byte
    for (int f = 0; f < 8; f++) begin
      cfg = {2'b11, 3'(f), 1'($random(seed))};
      wr(4'hF, {2'b00, cfg});
      wr(4'hF, 8'hE2);
      rd(4'hC, r);
      check(16'(r[5:0]), 16'(cfg));
    end
    check(16'(o_function_valid[0]), 16'h0001);
    $display("test function codes done");
    // null count, latch, ignored second latch, live read
    v = 16'($random(seed)) | 16'h0100;
    wr(4'hF, 8'h34);
    wr(4'hC, v[7:0]);
    wr(4'hC, v[15:8]);
    wr(4'hF, 8'hE2);
    rd(4'hC, r);
    check(16'(r[6:0]), 16'h0074);
    tick(3'h1, 1);
    wr(4'hF, 8'hE2);
    rd(4'hC, r);
    check(16'(r[6:0]), 16'h0034);
    check(16'(r[7]), 16'(o_out[0]));
    wr(4'hF, 8'h00);
    tick(3'h1, 3);
    wr(4'hF, 8'h00);
    rd(4'hF, r);
    rd16(4'hC, w);
    check(w, v);
    rd16(4'hC, w);
    check(w, expect_count(v, 1'b0, 3));
    $display("test latch done");
    // full scale in both radices and a decimal borrow
    // zero presets show the wrap to full scale in each radix
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h9999 : (k == 2) ? 16'h0100 : 16'h0000;
      wr(4'hF, {7'h18, 1'(k == 1 || k == 2 || k == 4)});
      wr(4'hC, v[7:0]);
      wr(4'hC, v[15:8]);
      tick(3'h1, 3);
      wr(4'hF, 8'h00);
      rd16(4'hC, w);
      check(w, expect_count(v, 1'(k == 1 || k == 2 || k == 4), 2));
    end
    $display("test radix done");
    // single-byte orders on counters 1 and 2
    wr(4'hF, 8'h50);
    wr(4'hD, 8'h37);
    tick(3'h2, 1);
    wr(4'hF, 8'h40);
    rd(4'hD, r);
    check(16'(r), 16'h0037);
    wr(4'hF, 8'hA0);
    wr(4'hE, 8'h12);
    tick(3'h4, 1);
    wr(4'hF, 8'h80);
    rd(4'hE, r);
    check(16'(r), 16'h0012);
    check(16'(o_function_valid), 16'h0007);
    $display("test byte orders done");
    // readback latches counters 1 and 2 together
    v = 16'($random(seed)) | 16'h0100;
    w = 16'($random(seed)) | 16'h0100;
    wr(4'hF, 8'h70);
    wr(4'hD, v[7:0]);
    wr(4'hD, v[15:8]);
    wr(4'hF, 8'hB0);
    wr(4'hE, w[7:0]);
    wr(4'hE, w[15:8]);
    tick(3'h6, 1);
    wr(4'hF, 8'hDC);
    tick(3'h6, 2);
    rd16(4'hD, u);
    check(u, v);
    rd16(4'hE, u);
    check(u, w);
    // gate low suspends counting, so a live read is safe
    i_gate = 3'h5;
    tick(3'h2, 2);
    rd16(4'hD, u);
    check(u, expect_count(v, 1'b0, 2));
    i_gate = 3'h7;
    // count and status latched together, status byte comes first
    wr(4'hF, 8'hC4);
    tick(3'h2, 1);
    rd(4'hD, r);
    check(16'(r[6:0]), 16'h0030);
    check(16'(r[7]), 16'(o_out[1]));
    rd16(4'hD, u);
    check(u, expect_count(v, 1'b0, 2));
    rd16(4'hD, u);
    check(u, expect_count(v, 1'b0, 3));
    $display("test readback done");
    complete_run();
  end
endmodule // tb
